// ### core/lsoc_map.svh
// Register offsets, field positions and timing constants of the leap and offset control block
`ifndef LSOC_MAP_SVH
`define LSOC_MAP_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define LSOC_CTRL_OFS      12'h000
`define LSOC_MSOFS_OFS     12'h004
`define LSOC_LOCOFS_OFS    12'h008
`define LSOC_LEAPTIM_OFS   12'h00c
`define LSOC_SCHTIM_OFS    12'h010
`define LSOC_SCHDAT_OFS    12'h014
`define LSOC_STATUS_OFS    12'h018
`define LSOC_MSTOT_OFS     12'h01c
`define LSOC_LOCTOT_OFS    12'h020

// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define LSOC_CTRL_DLY_BIT    4
`define LSOC_CTRL_MSCMD_BIT  8
`define LSOC_CTRL_LOCCMD_BIT 9
`define LSOC_LOC_UNIT_LSB    20
`define LSOC_DET_EN_RST      4'h0

// ----------------------------------------
// Time and range constants
// ----------------------------------------
`define LSOC_DAY_SECS       17'd86400
`define LSOC_HALF_DAY       19'sd43200
`define LSOC_WIN_LEAD_SECS  17'd10
`define LSOC_WIN_TAIL_DAYS  19'd3
`define LSOC_WIN_TAIL_MINS  19'd99
`define LSOC_MS_LIMIT       11'sd999
`define LSOC_LOC_LIMIT      18'sd99999
`define LSOC_LEAP_SS        6'd60
`define LSOC_MON_DEC        4'd12
`define LSOC_MON_MAR        4'd3
`define LSOC_MON_JUN        4'd6
`define LSOC_MON_SEP        4'd9
`define LSOC_DAY_31         5'd31
`define LSOC_DAY_30         5'd30
`define LSOC_SECS_MIN       32'sd60
`define LSOC_SECS_HOUR      32'sd3600

`endif

// ### core/lsoc_pkg.sv
// Shared types of the leap and offset control block
package lsoc_pkg;

  // Time of day as hours, minutes, seconds
  typedef struct packed {
    logic [4:0] hh;
    logic [5:0] mm;
    logic [5:0] ss;
  } lsoc_hms_type;

  // Calendar date
  typedef struct packed {
    logic [11:0] year;
    logic [3:0]  month;
    logic [4:0]  day;
  } lsoc_ymd_type;

  // Input source classes, also index of the detect enables
  typedef enum logic [1:0] {
    LSOC_SRC_TC    = 2'b00,
    LSOC_SRC_RADIO = 2'b01,
    LSOC_SRC_MODEM = 2'b10,
    LSOC_SRC_SER   = 2'b11
  } lsoc_src_type;

  // Local offset time units
  typedef enum logic [2:0] {
    LSOC_UNIT_SEC  = 3'b000,
    LSOC_UNIT_MIN  = 3'b001,
    LSOC_UNIT_HOUR = 3'b010,
    LSOC_UNIT_DAY  = 3'b011
  } lsoc_unit_type;

endpackage : lsoc_pkg

// ### core/lsoc_top.sv
// Leap second detection and scheduling, millisecond and local offsets, APB register slave
//
// Chosen here: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`include "lsoc_map.svh"

module lsoc_top (
  // Clock and reset
  input  wire logic                  i_core_clk,
  input  wire logic                  i_arst_n,
  // APB slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [11:0]           paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  // Time base
  input  wire logic                  i_sec_tick,
  input  wire lsoc_pkg::lsoc_hms_type i_utc_time,
  input  wire lsoc_pkg::lsoc_ymd_type i_utc_date,
  input  wire lsoc_pkg::lsoc_hms_type i_local_time,
  input  wire lsoc_pkg::lsoc_ymd_type i_local_date,
  input  wire logic                  i_time_load,
  input  wire logic                  i_out_discont,
  // Input source samples
  input  wire logic                  i_src_valid,
  input  wire lsoc_pkg::lsoc_src_type i_src_class,
  input  wire lsoc_pkg::lsoc_hms_type i_src_time,
  // Results
  output logic                       o_leap_apply,
  output logic                       o_leap_positive,
  output logic                       o_leap_pending,
  output logic                       o_window_open,
  output logic signed [31:0]         o_ms_offset_total,
  output logic signed [31:0]         o_local_offset_total
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [16:0] hms_to_sod(input lsoc_pkg::lsoc_hms_type t);
    hms_to_sod = 17'(t.hh * `LSOC_SECS_HOUR) + 17'(t.mm * `LSOC_SECS_MIN) + 17'(t.ss);
  endfunction : hms_to_sod
  function automatic logic leap_date(input lsoc_pkg::lsoc_ymd_type d);
    leap_date = (d.month == `LSOC_MON_DEC && d.day == `LSOC_DAY_31) ||
                (d.month == `LSOC_MON_MAR && d.day == `LSOC_DAY_31) ||
                (d.month == `LSOC_MON_JUN && d.day == `LSOC_DAY_30) ||
                (d.month == `LSOC_MON_SEP && d.day == `LSOC_DAY_30);
  endfunction : leap_date
  // Step beyond the expected +1 s, folded across midnight
  function automatic logic signed [18:0] src_step(input logic [16:0] now_s, input logic [16:0] last_s);
    logic signed [18:0] d;
    d = $signed({2'b00, now_s}) - $signed({2'b00, last_s});
    if (d > `LSOC_HALF_DAY) begin
      d = d - $signed({2'b00, `LSOC_DAY_SECS});
    end else if (d < -`LSOC_HALF_DAY) begin
      d = d + $signed({2'b00, `LSOC_DAY_SECS});
    end
    src_step = d - 19'sd1;
  endfunction : src_step
  function automatic logic signed [31:0] to_secs(input logic signed [17:0] v, input logic [2:0] u);
    case (u)
      lsoc_pkg::LSOC_UNIT_MIN:  to_secs = 32'(v) * `LSOC_SECS_MIN;
      lsoc_pkg::LSOC_UNIT_HOUR: to_secs = 32'(v) * `LSOC_SECS_HOUR;
      lsoc_pkg::LSOC_UNIT_DAY:  to_secs = 32'(v) * $signed({15'h0000, `LSOC_DAY_SECS});
      default:                  to_secs = 32'(v);
    endcase
  endfunction : to_secs

  // ----------------------------------------
  // Registers and decode
  // ----------------------------------------
  logic [3:0]                det_en_ff;
  logic                      dly_en_ff, ms_cmd_ff, loc_cmd_ff, pend_ff, pend_pos_ff, have_last_ff, apply_ff;
  logic signed [10:0]        ms_val_ff, ms_wr;
  logic signed [17:0]        loc_val_ff, loc_wr;
  logic [2:0]                loc_unit_ff;
  lsoc_pkg::lsoc_hms_type    leap_time_ff, sch_time_ff;
  lsoc_pkg::lsoc_ymd_type    sch_date_ff;
  logic signed [7:0]         leap_cnt_ff;
  logic [18:0]               win_cnt_ff;
  logic [16:0]               last_sod_ff, src_sod;
  logic [31:0]               prdata_ff, rd_val;
  logic signed [31:0]        ms_tot_ff, loc_tot_ff;
  logic                      wr_en, rd_setup, hit, cls_en, win_open, is_pos, is_neg;
  logic                      detect_ok, leap_fire, sched_hit, loc_now;
  logic signed [18:0]        step;

  assign pready   = 1'b1;
  assign wr_en    = psel && penable && pwrite;
  assign rd_setup = psel && !penable && !pwrite;
  assign pslverr  = psel && penable && !hit;
  assign prdata   = prdata_ff;
  always_comb begin
    hit    = 1'b1;
    rd_val = 32'h0000_0000;
    if (paddr == `LSOC_CTRL_OFS) begin
      rd_val = {27'h0000000, dly_en_ff, det_en_ff};
    end else if (paddr == `LSOC_MSOFS_OFS) begin
      rd_val = 32'(ms_val_ff);
    end else if (paddr == `LSOC_LOCOFS_OFS) begin
      rd_val = {9'h000, loc_unit_ff, 2'b00, loc_val_ff};
    end else if (paddr == `LSOC_LEAPTIM_OFS) begin
      rd_val = {15'h0000, leap_time_ff};
    end else if (paddr == `LSOC_SCHTIM_OFS) begin
      rd_val = {15'h0000, sch_time_ff};
    end else if (paddr == `LSOC_SCHDAT_OFS) begin
      rd_val = {11'h000, sch_date_ff};
    end else if (paddr == `LSOC_STATUS_OFS) begin
      rd_val = {16'h0000, leap_cnt_ff, 5'h00, win_open, pend_pos_ff, pend_ff};
    end else if (paddr == `LSOC_MSTOT_OFS) begin
      rd_val = ms_tot_ff;
    end else if (paddr == `LSOC_LOCTOT_OFS) begin
      rd_val = loc_tot_ff;
    end else begin
      hit = 1'b0;
    end
  end
  // Read data is captured in the setup phase so the access phase needs no wait
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      prdata_ff <= 32'h0000_0000;
    end else if (rd_setup) begin
      prdata_ff <= rd_val;
    end
  end
  // Out-of-range writes saturate
  assign ms_wr  = ($signed(pwdata[10:0]) > `LSOC_MS_LIMIT) ? `LSOC_MS_LIMIT :
                  ($signed(pwdata[10:0]) < -`LSOC_MS_LIMIT) ? -`LSOC_MS_LIMIT : $signed(pwdata[10:0]);
  assign loc_wr = ($signed(pwdata[17:0]) > `LSOC_LOC_LIMIT) ? `LSOC_LOC_LIMIT :
                  ($signed(pwdata[17:0]) < -`LSOC_LOC_LIMIT) ? -`LSOC_LOC_LIMIT : $signed(pwdata[17:0]);

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      det_en_ff    <= `LSOC_DET_EN_RST;
      ms_val_ff    <= 11'sd0;
      loc_val_ff   <= 18'sd0;
      loc_unit_ff  <= 3'h0;
      leap_time_ff <= '0;
      sch_time_ff  <= '0;
      sch_date_ff  <= '0;
    end else if (wr_en) begin
      if (paddr == `LSOC_CTRL_OFS) begin
        det_en_ff <= pwdata[3:0];
      end else if (paddr == `LSOC_MSOFS_OFS) begin
        ms_val_ff <= ms_wr;
      end else if (paddr == `LSOC_LOCOFS_OFS) begin
        loc_val_ff  <= loc_wr;
        loc_unit_ff <= pwdata[`LSOC_LOC_UNIT_LSB +: 3];
      end else if (paddr == `LSOC_LEAPTIM_OFS) begin
        leap_time_ff <= pwdata[16:0];
      end else if (paddr == `LSOC_SCHTIM_OFS) begin
        sch_time_ff <= pwdata[16:0];
      end else if (paddr == `LSOC_SCHDAT_OFS) begin
        sch_date_ff <= pwdata[20:0];
      end
    end
  end
  // Commands live one cycle, so they always read back as no
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ms_cmd_ff  <= 1'b0;
      loc_cmd_ff <= 1'b0;
    end else begin
      ms_cmd_ff  <= wr_en && paddr == `LSOC_CTRL_OFS && pwdata[`LSOC_CTRL_MSCMD_BIT];
      loc_cmd_ff <= wr_en && paddr == `LSOC_CTRL_OFS && pwdata[`LSOC_CTRL_LOCCMD_BIT];
    end
  end
  // Software write wins over the self-clear
  assign sched_hit = dly_en_ff && i_sec_tick && i_local_time == sch_time_ff && i_local_date == sch_date_ff;
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      dly_en_ff <= 1'b0;
    end else if (wr_en && paddr == `LSOC_CTRL_OFS) begin
      dly_en_ff <= pwdata[`LSOC_CTRL_DLY_BIT];
    end else if (sched_hit) begin
      dly_en_ff <= 1'b0;
    end
  end

  // ----------------------------------------
  // Offsets
  // ----------------------------------------
  assign loc_now = sched_hit || (loc_cmd_ff && !dly_en_ff);

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ms_tot_ff <= 32'sd0;
    end else if (i_time_load) begin
      ms_tot_ff <= 32'sd0;
    end else if (ms_cmd_ff) begin
      ms_tot_ff <= ms_tot_ff + 32'(ms_val_ff);
    end
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      loc_tot_ff <= 32'sd0;
    end else if (i_time_load) begin
      loc_tot_ff <= 32'sd0;
    end else if (loc_now) begin
      loc_tot_ff <= loc_tot_ff + to_secs(loc_val_ff, loc_unit_ff);
    end
  end
  assign o_ms_offset_total    = ms_tot_ff;
  assign o_local_offset_total = loc_tot_ff;

  // ----------------------------------------
  // Leap detection window
  // ----------------------------------------
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      win_cnt_ff <= 19'h00000;
    end else if (i_sec_tick && leap_date(i_utc_date) &&
                 hms_to_sod(i_utc_time) == `LSOC_DAY_SECS - `LSOC_WIN_LEAD_SECS) begin
      win_cnt_ff <= 19'(`LSOC_WIN_LEAD_SECS) + `LSOC_WIN_TAIL_DAYS * 19'(`LSOC_DAY_SECS) +
                    `LSOC_WIN_TAIL_MINS * 19'(`LSOC_SECS_MIN);
    end else if (i_sec_tick && win_cnt_ff != 19'h00000) begin
      win_cnt_ff <= win_cnt_ff - 19'd1;
    end
  end
  assign win_open      = win_cnt_ff != 19'h00000;
  assign o_window_open = win_open;

  // ----------------------------------------
  // Step detection
  // ----------------------------------------
  // Input showing second 60 is a positive leap in itself
  assign src_sod   = hms_to_sod(i_src_time);
  assign step      = src_step(src_sod, last_sod_ff);
  assign cls_en    = det_en_ff[i_src_class];
  assign is_pos    = i_src_time.ss == `LSOC_LEAP_SS || step == -19'sd1;
  assign is_neg    = i_src_time.ss != `LSOC_LEAP_SS && step == 19'sd1;
  assign detect_ok = i_src_valid && have_last_ff && cls_en && win_open && (is_pos || is_neg);
  // Second 60 is stored as 59 so the following midnight is not seen as a step
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      last_sod_ff  <= 17'h00000;
      have_last_ff <= 1'b0;
    end else if (i_src_valid) begin
      last_sod_ff  <= src_sod - 17'(i_src_time.ss == `LSOC_LEAP_SS);
      have_last_ff <= 1'b1;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      leap_cnt_ff <= 8'sd0;
    end else if (detect_ok) begin
      leap_cnt_ff <= is_pos ? leap_cnt_ff + 8'sd1 : leap_cnt_ff - 8'sd1;
    end
  end

  // ----------------------------------------
  // Pending leap and application
  // ----------------------------------------
  assign leap_fire = pend_ff && ((i_sec_tick && i_local_time == leap_time_ff) || i_out_discont);
  // A new detection wins over the clear of the previous one
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pend_ff     <= 1'b0;
      pend_pos_ff <= 1'b0;
    end else if (detect_ok) begin
      pend_ff     <= 1'b1;
      pend_pos_ff <= is_pos;
    end else if (leap_fire) begin
      pend_ff <= 1'b0;
    end
  end
  // Generator inserts second 60 when positive, skips 59 when negative
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      apply_ff        <= 1'b0;
      o_leap_positive <= 1'b0;
    end else begin
      apply_ff <= leap_fire;
      if (leap_fire) begin
        o_leap_positive <= pend_pos_ff;
      end
    end
  end
  assign o_leap_apply   = apply_ff;
  assign o_leap_pending = pend_ff;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  pend_on_detect_a: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    detect_ok |=> pend_ff ##0 pend_pos_ff == $past(is_pos)) else $error("pending not set on detect");
  leap_at_time_a: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    (pend_ff && i_sec_tick && i_local_time == leap_time_ff && !detect_ok) |=> o_leap_apply && !pend_ff)
    else $error("leap not applied at local time");
  discont_apply_a: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    (pend_ff && i_out_discont && !detect_ok) |=> o_leap_apply ##1 !o_leap_apply) else $error("discontinuity missed");
  no_detect_off_a: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    (i_src_valid && (!cls_en || !win_open)) |=> $stable(leap_cnt_ff)) else $error("count changed off window");
  window_len_a: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    (i_sec_tick && leap_date(i_utc_date) && hms_to_sod(i_utc_time) == 17'd86390) |=> win_cnt_ff == 19'd265150)
    else $error("window length wrong");
  ms_cmd_clear_a: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    ms_cmd_ff |=> !ms_cmd_ff) else $error("ms command stuck");
  ms_cumul_a: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    (ms_cmd_ff && !i_time_load) |=> ms_tot_ff == $past(ms_tot_ff) + 32'($past(ms_val_ff)))
    else $error("ms offset not accumulated");
  imm_blocked_a: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    (loc_cmd_ff && dly_en_ff && !sched_hit && !i_time_load) |=> $stable(loc_tot_ff)) else $error("blocked offset applied");
  delay_clear_a: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    (sched_hit && !wr_en) |=> !dly_en_ff) else $error("delay enable kept");
  load_clear_a: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    i_time_load |=> ms_tot_ff == 32'sd0 && loc_tot_ff == 32'sd0) else $error("offsets survive time load");

endmodule : lsoc_top

// ### dv/lsoc_src_model.sv
// Behavioural time source: second ticks, UTC time and date, input-source samples
`timescale 1ns/1ps
module lsoc_src_model #(
  parameter int TICK_CYC = 8
) (
  // Clock
  input  wire logic                   i_clk,
  // Bench control
  input  wire logic                   i_set,
  input  wire logic [16:0]            i_set_sod,
  input  wire lsoc_pkg::lsoc_ymd_type i_set_date,
  input  wire logic signed [1:0]      i_skew,
  input  wire lsoc_pkg::lsoc_src_type i_class,
  // Time and samples
  output logic                        o_tick,
  output lsoc_pkg::lsoc_hms_type      o_time,
  output lsoc_pkg::lsoc_ymd_type      o_date,
  output logic                        o_src_valid,
  output lsoc_pkg::lsoc_src_type      o_src_class,
  output lsoc_pkg::lsoc_hms_type      o_src_time
);
  int cnt = 0;
  int sod = 0;
  int skew = 0;

  function automatic lsoc_pkg::lsoc_hms_type to_hms(input int s);
    int w;
    w = ((s % 86400) + 86400) % 86400;
    return '{hh: 5'(w / 3600), mm: 6'((w / 60) % 60), ss: 6'(w % 60)};
  endfunction : to_hms

  assign o_time = to_hms(sod);

  initial begin
    o_tick = 1'b0;
    o_src_valid = 1'b0;
    o_src_time = '0;
    o_date = '0;
  end

  // The sample time lines toggle between samples so a stale value is never mistaken for data
  always @(posedge i_clk) begin
    skew <= skew + int'(i_skew);
    o_tick <= 1'b0;
    o_src_valid <= 1'b0;
    o_src_class <= i_class;
    o_src_time <= ~o_src_time;
    if (i_set) begin
      sod <= int'(i_set_sod);
      o_date <= i_set_date;
      cnt <= 0;
      skew <= 0;
    end else if (cnt == TICK_CYC - 1) begin
      cnt <= 0;
      sod <= sod + 1;
      o_tick <= 1'b1;
      o_src_valid <= 1'b1;
      o_src_time <= to_hms(sod + 1 + skew + int'(i_skew));
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule : lsoc_src_model

// ### dv/lsoc_top_tb.sv
// Self-checking bench of the leap and offset control block
`timescale 1ns/1ps
`include "lsoc_map.svh"
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin n_mismatch++; $display("mismatch %s exp %0h got %0h", nm, e, g); end end
module lsoc_top_tb;
  logic                   clk = 1'b0;
  logic                   rst_n = 1'b0;
  logic                   psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0]            paddr = '0;
  logic [31:0]            pwdata = '0, prdata;
  logic                   pready, pslverr, tload = 1'b0, discont = 1'b0, m_set = 1'b0;
  logic [16:0]            m_sod = '0;
  logic signed [1:0]      m_skew = '0;
  lsoc_pkg::lsoc_ymd_type m_date = '0, date;
  lsoc_pkg::lsoc_src_type m_class = lsoc_pkg::LSOC_SRC_TC, s_class;
  lsoc_pkg::lsoc_hms_type utime, s_time;
  logic                   tick, s_valid, lapply, lpos, lpend, wopen;
  logic signed [31:0]     ms_tot, loc_tot;
  int                     n_mismatch = 0, check_count = 0, cyc = 0;
  int                     dm[6] = '{12, 1, 3, 6, 9, 12};
  int                     dd[6] = '{30, 31, 31, 30, 30, 31};
  logic                   dx[6] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1};

  always #5 clk = ~clk;

  lsoc_top uut (
    .i_core_clk(clk), .i_arst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .i_sec_tick(tick), .i_utc_time(utime), .i_utc_date(date), .i_local_time(utime),
    .i_local_date(date), .i_time_load(tload), .i_out_discont(discont), .i_src_valid(s_valid),
    .i_src_class(s_class), .i_src_time(s_time), .o_leap_apply(lapply), .o_leap_positive(lpos),
    .o_leap_pending(lpend), .o_window_open(wopen), .o_ms_offset_total(ms_tot),
    .o_local_offset_total(loc_tot)
  );

  lsoc_src_model #(.TICK_CYC(8)) src (
    .i_clk(clk), .i_set(m_set), .i_set_sod(m_sod), .i_set_date(m_date), .i_skew(m_skew),
    .i_class(m_class), .o_tick(tick), .o_time(utime), .o_date(date), .o_src_valid(s_valid),
    .o_src_class(s_class), .o_src_time(s_time)
  );

  // ----------------------------------------
  // Expectations and drivers
  // ----------------------------------------
  function automatic int sat(input int v, input int lim);
    return (v > lim) ? lim : (v < -lim) ? -lim : v;
  endfunction : sat

  function automatic int unit_secs(input int u);
    return (u == 1) ? 60 : (u == 2) ? 3600 : (u == 3) ? int'(`LSOC_DAY_SECS) : 1;
  endfunction : unit_secs

  function automatic lsoc_pkg::lsoc_ymd_type mk_date(input int m, input int d);
    return '{year: 12'd2024, month: 4'(m), day: 5'(d)};
  endfunction : mk_date

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] v;
    logic        e;
    apb(1'b1, a, d, v, e);
  endtask : wr

  task automatic rdc(input logic [11:0] a, input logic [31:0] ex, input string nm);
    logic [31:0] v;
    logic        e;
    apb(1'b0, a, '0, v, e);
    `CHK(nm, ex, v)
  endtask : rdc

  task automatic cyc_wait(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc_wait

  task automatic ticks(input int n);
    repeat (n) @(posedge clk iff tick);
  endtask : ticks

  task automatic to_ss(input int s);
    do @(posedge clk iff tick); while (utime.ss != 6'(s));
  endtask : to_ss

  task automatic pulse(input logic to_discont);
    @(posedge clk);
    if (to_discont) begin
      discont <= 1'b1;
    end else begin
      tload <= 1'b1;
    end
    @(posedge clk);
    discont <= 1'b0;
    tload <= 1'b0;
  endtask : pulse

  task automatic skew(input logic signed [1:0] s);
    @(posedge clk);
    m_skew <= s;
    @(posedge clk);
    m_skew <= '0;
  endtask : skew

  task automatic m_time(input logic [16:0] s, input lsoc_pkg::lsoc_ymd_type dt);
    @(posedge clk);
    m_sod <= s;
    m_date <= dt;
    m_set <= 1'b1;
    @(posedge clk);
    m_set <= 1'b0;
  endtask : m_time

  task automatic wait_apply(output int n);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (lapply !== 1'b1);
  endtask : wait_apply

  task automatic reset_dut();
    rst_n <= 1'b0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
  endtask : reset_dut

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : wrap_up

  // Hang guard, far above the few hundred cycles the sequence needs
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      wrap_up();
    end
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    int          v, u, exp_ms, exp_loc, n;
    logic [31:0] rv;
    logic        e;
    void'($urandom(76704));
    exp_ms = 0;
    exp_loc = 0;
    reset_dut();
    m_time(17'd43200, mk_date(5, 15));
    rdc(`LSOC_STATUS_OFS, '0, "status reset");
    rdc(`LSOC_CTRL_OFS, '0, "ctrl reset");
    apb(1'b0, 12'h024, '0, rv, e);
    `CHK("unmapped data", 32'h0, rv)
    `CHK("unmapped error", 1'b1, e)
    `CHK("ready", 1'b1, pready)
    for (int i = 0; i < 6; i++) begin
      v = (i == 0) ? 1000 : (i == 1) ? -1024 : int'($urandom_range(1998)) - 999;
      exp_ms += sat(v, 999);
      wr(`LSOC_MSOFS_OFS, 32'(v) & 32'h7ff);
      wr(`LSOC_CTRL_OFS, 32'h1 << `LSOC_CTRL_MSCMD_BIT);
      cyc_wait(3);
      `CHK("ms total", 32'(exp_ms), ms_tot)
    end
    rdc(`LSOC_CTRL_OFS, '0, "ms command");
    for (int i = 0; i < 6; i++) begin
      u = i % 4;
      v = (i == 4) ? 120000 : int'($urandom_range(1998)) - 999;
      exp_loc += sat(v, 99999) * unit_secs(u);
      wr(`LSOC_LOCOFS_OFS, (32'(v) & 32'h3ffff) | (32'(u) << `LSOC_LOC_UNIT_LSB));
      wr(`LSOC_CTRL_OFS, 32'h1 << `LSOC_CTRL_LOCCMD_BIT);
      cyc_wait(3);
      `CHK("local total", 32'(exp_loc), loc_tot)
    end
    rdc(`LSOC_CTRL_OFS, '0, "local command");
    wr(`LSOC_LOCOFS_OFS, 32'd7 | (32'd1 << `LSOC_LOC_UNIT_LSB));
    wr(`LSOC_SCHTIM_OFS, 32'({5'd10, 6'd0, 6'd3}));
    wr(`LSOC_SCHDAT_OFS, 32'(mk_date(5, 10)));
    m_time(17'd36000, mk_date(5, 10));
    wr(`LSOC_CTRL_OFS, (32'h1 << `LSOC_CTRL_DLY_BIT) | (32'h1 << `LSOC_CTRL_LOCCMD_BIT));
    cyc_wait(3);
    `CHK("immediate while delayed", 32'(exp_loc), loc_tot)
    to_ss(2);
    cyc_wait(2);
    `CHK("scheduled early", 32'(exp_loc), loc_tot)
    to_ss(3);
    cyc_wait(2);
    exp_loc += 420;
    `CHK("scheduled apply", 32'(exp_loc), loc_tot)
    rdc(`LSOC_CTRL_OFS, '0, "delay enable");
    pulse(1'b0);
    cyc_wait(2);
    `CHK("ms after load", 32'h0, ms_tot)
    `CHK("local after load", 32'h0, loc_tot)

    // ----------------------------------------
    // Leap detection
    // ----------------------------------------
    m_time(17'd43200, mk_date(5, 15));
    wr(`LSOC_CTRL_OFS, 32'hf);
    ticks(2);
    skew(2'sd1);
    ticks(2);
    cyc_wait(2);
    rdc(`LSOC_STATUS_OFS, '0, "step closed window");
    for (int i = 0; i < 6; i++) begin
      reset_dut();
      m_time(`LSOC_DAY_SECS - 17'd11, mk_date(dm[i], dd[i]));
      `CHK("window before lead", 1'b0, wopen)
      ticks(1);
      cyc_wait(2);
      `CHK("window at lead", dx[i], wopen)
    end
    wr(`LSOC_LEAPTIM_OFS, 32'({5'd1, 6'd0, 6'd3}));
    wr(`LSOC_CTRL_OFS, 32'h1);
    m_class <= lsoc_pkg::LSOC_SRC_RADIO;
    ticks(2);
    skew(2'sd1);
    ticks(2);
    cyc_wait(2);
    rdc(`LSOC_STATUS_OFS, 32'h4, "step other class");
    m_class <= lsoc_pkg::LSOC_SRC_TC;
    ticks(2);
    skew(2'sd1);
    ticks(1);
    cyc_wait(3);
    `CHK("pending set", 1'b1, lpend)
    rdc(`LSOC_STATUS_OFS, 32'hff05, "negative leap");
    m_time(17'd3600, mk_date(12, 31));
    to_ss(2);
    cyc_wait(2);
    `CHK("pending before time", 1'b1, lpend)
    wait_apply(n);
    `CHK("apply time", 17'({5'd1, 6'd0, 6'd3}), utime)
    `CHK("leap sign", 1'b0, lpos)
    @(negedge clk);
    `CHK("pending cleared", 1'b0, lpend)
    skew(-2'sd1);
    ticks(1);
    cyc_wait(3);
    rdc(`LSOC_STATUS_OFS, 32'h7, "positive leap");
    pulse(1'b1);
    wait_apply(n);
    `CHK("discontinuity delay", 1, n)
    `CHK("inserted second", 1'b1, lpos)
    @(negedge clk);
    `CHK("pending after discontinuity", 1'b0, lpend)
    rdc(`LSOC_STATUS_OFS, 32'h6, "count restored");
    wrap_up();
  end
endmodule : lsoc_top_tb
